//--- hw/timer_counter_clock_core.sv
// three-channel 16-bit timer counter core with clock selection and an AXI4-Lite slave
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module timer_counter_clock_core #(
  parameter int NUM_CH = tc_pkg::NUM_CH,
  parameter int CNT_W = tc_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] ext_clock_pins,
  input wire logic [NUM_CH-1:0] io_line_a_in,
  output logic [NUM_CH-1:0] io_line_a_out,
  output logic [NUM_CH-1:0] io_line_a_oe_n,
  input wire logic [NUM_CH-1:0] io_line_b_in,
  output logic [NUM_CH-1:0] io_line_b_out,
  output logic [NUM_CH-1:0] io_line_b_oe_n,
  output logic [NUM_CH-1:0] irq
);
  import tc_pkg::*;

  // refuse shapes the chaining and register map cannot serve
  if (NUM_CH != 3) begin : g_chk_ch
    $error("timer_counter_clock_core needs exactly three channels");
  end
  if (CNT_W < 2 || CNT_W > 32) begin : g_chk_w
    $error("timer_counter_clock_core counter width must be 2 to 32");
  end

  // true when the address names an existing register
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] ofs;
    ofs = a & (CH_STRIDE - 8'h01);
    if (a == ADR_BCR || a == ADR_BMR) begin
      addr_mapped = 1'b1;
    end else if ((a / CH_STRIDE) < 8'(NUM_CH)) begin
      addr_mapped = (ofs <= OFS_IMASK) && (ofs[1:0] == 2'h0);
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction : addr_mapped

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction : merge_strb

  logic [ADDR_W-1:0] awaddr_r;
  logic aw_hold_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_hold_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_val;
  logic [5:0] bmr_r;
  logic sync_trig;
  logic [PRE_W-1:0] pre_r;
  logic [2:0] xpin_s1_r;
  logic [2:0] xpin_s2_r;
  logic [NUM_CH-1:0] ioa_s1_r;
  logic [NUM_CH-1:0] ioa_s2_r;
  logic [2:0] xc_lvl;
  logic [NUM_CH-1:0] ioa_lvl;
  logic [15:0] mode_r [NUM_CH];
  logic [CNT_W-1:0] cv_r [NUM_CH];
  logic [CNT_W-1:0] rb_r [NUM_CH];
  logic [CNT_W-1:0] rc_r [NUM_CH];
  logic [NUM_FLAGS-1:0] flags_r [NUM_CH];
  logic [NUM_FLAGS-1:0] imask_r [NUM_CH];
  logic [NUM_CH-1:0] en_r;
  logic [NUM_CH-1:0] out_a_r;
  logic [NUM_CH-1:0] out_b_r;
  logic [NUM_CH-1:0] irq_r;

  // write channels: address and data taken independently, answered once both held
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= addr_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel: one outstanding read, data registered one cycle after the address
  assign s_axi_arready = !rvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // read mux; write-only and unmapped words read zero
  always_comb begin
    rd_val = 32'h00000000;
    if (s_axi_araddr == ADR_BMR) begin
      rd_val = 32'(bmr_r);
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (s_axi_araddr == 8'(i) * CH_STRIDE + OFS_MODE) begin
        rd_val = 32'(mode_r[i]);
      end else if (s_axi_araddr == 8'(i) * CH_STRIDE + OFS_CV) begin
        rd_val = 32'(cv_r[i]);
      end else if (s_axi_araddr == 8'(i) * CH_STRIDE + OFS_RB) begin
        rd_val = 32'(rb_r[i]);
      end else if (s_axi_araddr == 8'(i) * CH_STRIDE + OFS_RC) begin
        rd_val = 32'(rc_r[i]);
      end else if (s_axi_araddr == 8'(i) * CH_STRIDE + OFS_STAT) begin
        rd_val = 32'(flags_r[i]);
        rd_val[ST_CLOCK_ENABLED_STATUS_BIT] = en_r[i];
      end else if (s_axi_araddr == 8'(i) * CH_STRIDE + OFS_IMASK) begin
        rd_val = 32'(imask_r[i]);
      end
    end
  end

  // block registers: chaining selects and the all-channel sync strobe
  assign sync_trig = wr_go && awaddr_r == ADR_BCR && wstrb_r[0] && wdata_r[BCR_SYNC_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bmr_r <= BMR_RST;
    end else if (wr_go && awaddr_r == ADR_BMR && wstrb_r[0]) begin
      bmr_r <= wdata_r[5:0];
    end
  end

  // free-running prescaler; its bits are the divided internal clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // two-flop synchronisers for the external clock pins and line A; line B is not synchronised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xpin_s1_r <= 3'h0;
      xpin_s2_r <= 3'h0;
      ioa_s1_r <= '0;
      ioa_s2_r <= '0;
    end else begin
      xpin_s1_r <= ext_clock_pins;
      xpin_s2_r <= xpin_s1_r;
      ioa_s1_r <= io_line_a_in;
      ioa_s2_r <= ioa_s1_r;
    end
  end

  // external clock input k comes from pin k, nothing, or line A of another channel
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (bmr_r[2*k +: 2] == XSEL_PIN) begin
        xc_lvl[k] = xpin_s2_r[k];
      end else if (bmr_r[2*k +: 2] == XSEL_NEXT) begin
        xc_lvl[k] = ioa_lvl[(k + 1) % 3];
      end else if (bmr_r[2*k +: 2] == XSEL_PREV) begin
        xc_lvl[k] = ioa_lvl[(k + 2) % 3];
      end else begin
        xc_lvl[k] = 1'b0;
      end
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    mode_s md;
    logic [7:0] base;
    logic ctrl_wr;
    logic cmd_en;
    logic cmd_dis;
    logic software_trigger_bit;
    logic sel_lvl;
    logic gate;
    logic clk_lvl;
    logic clk_prev_r;
    logic cnt_edge;
    logic ioa_prev_r;
    logic ldb_evt;
    logic cmp_evt;
    logic ovf_evt;
    logic trig;
    logic run_r;
    logic pend_r;
    logic stat_clr;
    logic [NUM_FLAGS-1:0] evts;

    assign md = mode_r[i];
    assign base = 8'(i) * CH_STRIDE;
    assign ctrl_wr = wr_go && awaddr_r == base + OFS_CTRL && wstrb_r[0];
    assign cmd_en = ctrl_wr && wdata_r[CTRL_EN_BIT];
    assign cmd_dis = ctrl_wr && wdata_r[CTRL_DIS_BIT];
    assign software_trigger_bit = ctrl_wr && wdata_r[CTRL_SOFTWARE_TRIGGER_BIT_BIT];
    assign stat_clr = rd_go && s_axi_araddr == base + OFS_STAT;
    assign ioa_lvl[i] = md.wave ? out_a_r[i] : ioa_s2_r[i];

    // writable channel registers
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_r[i] <= MODE_RST;
        rc_r[i] <= '0;
        imask_r[i] <= IMASK_RST;
      end else if (wr_go) begin
        if (awaddr_r == base + OFS_MODE) begin
          mode_r[i] <= 16'(merge_strb(32'(mode_r[i]), wdata_r, wstrb_r)) & 16'h0FFF;
        end else if (awaddr_r == base + OFS_RC) begin
          rc_r[i] <= CNT_W'(merge_strb(32'(rc_r[i]), wdata_r, wstrb_r));
        end else if (awaddr_r == base + OFS_IMASK && wstrb_r[0]) begin
          imask_r[i] <= wdata_r[NUM_FLAGS-1:0];
        end
      end
    end

    // clock source, inversion and burst gate
    always_comb begin
      case (md.clk_sel)
        CLK_DIV2: sel_lvl = pre_r[DIV2_BIT];
        CLK_DIV8: sel_lvl = pre_r[DIV8_BIT];
        CLK_DIV32: sel_lvl = pre_r[DIV32_BIT];
        CLK_DIV128: sel_lvl = pre_r[DIV128_BIT];
        CLK_DIV1024: sel_lvl = pre_r[DIV1024_BIT];
        CLK_XC0: sel_lvl = xc_lvl[0];
        CLK_XC1: sel_lvl = xc_lvl[1];
        default: sel_lvl = xc_lvl[2];
      endcase
      case (md.burst)
        BURST_NONE: gate = 1'b1;
        BURST_XC0: gate = xc_lvl[0];
        BURST_XC1: gate = xc_lvl[1];
        default: gate = xc_lvl[2];
      endcase
    end
    assign clk_lvl = (sel_lvl ^ md.invert) & gate;
    assign cnt_edge = clk_lvl && !clk_prev_r && en_r[i] && run_r;

    // channel events
    assign ldb_evt = !md.wave && ioa_s2_r[i] && !ioa_prev_r;
    assign cmp_evt = md.wave && cnt_edge && !pend_r && CNT_W'(cv_r[i] + 1'b1) == rc_r[i];
    assign ovf_evt = cnt_edge && !pend_r && (&cv_r[i]);
    assign trig = software_trigger_bit || sync_trig || (cmp_evt && md.cmp_trig);
    assign evts = {ldb_evt, cmp_evt, ovf_evt};

    // edge history of the selected clock and of line A
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        clk_prev_r <= 1'b0;
        ioa_prev_r <= 1'b0;
      end else begin
        clk_prev_r <= clk_lvl;
        ioa_prev_r <= ioa_s2_r[i];
      end
    end

    // clock enable: disable command wins over enable in the same write
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        en_r[i] <= 1'b0;
      end else if (cmd_dis) begin
        en_r[i] <= 1'b0;
      end else if (ldb_evt && md.ldb_dis) begin
        en_r[i] <= 1'b0;
      end else if (cmp_evt && md.cmp_dis) begin
        en_r[i] <= 1'b0;
      end else if (cmd_en) begin
        en_r[i] <= 1'b1;
      end
    end

    // start and stop, only while enabled; a trigger beats a stop
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        run_r <= 1'b0;
      end else if (!en_r[i]) begin
        run_r <= 1'b0;
      end else if (trig) begin
        run_r <= 1'b1;
      end else if ((ldb_evt && md.ldb_stop) || (cmp_evt && md.cmp_stop)) begin
        run_r <= 1'b0;
      end
    end

    // trigger waits for the next valid clock edge before zeroing the count
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pend_r <= 1'b0;
      end else if (!en_r[i]) begin
        pend_r <= 1'b0;
      end else if (trig) begin
        pend_r <= 1'b1;
      end else if (cnt_edge) begin
        pend_r <= 1'b0;
      end
    end

    // counter and capture register B
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cv_r[i] <= '0;
        rb_r[i] <= '0;
      end else begin
        if (cnt_edge) begin
          cv_r[i] <= pend_r ? '0 : CNT_W'(cv_r[i] + 1'b1);
        end
        if (ldb_evt) begin
          rb_r[i] <= cv_r[i];
        end
      end
    end

    // sticky status flags cleared by a status read; a new event wins
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flags_r[i] <= '0;
      end else begin
        flags_r[i] <= (flags_r[i] & {NUM_FLAGS{!stat_clr}}) | evts;
      end
    end

    // line outputs toggle on compare C and overflow in waveform mode
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_a_r[i] <= 1'b0;
        out_b_r[i] <= 1'b0;
      end else begin
        if (cmp_evt) begin
          out_a_r[i] <= !out_a_r[i];
        end
        if (md.wave && ovf_evt) begin
          out_b_r[i] <= !out_b_r[i];
        end
      end
    end

    // per-channel interrupt request
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        irq_r[i] <= 1'b0;
      end else begin
        irq_r[i] <= |(flags_r[i] & imask_r[i]);
      end
    end

    assign io_line_a_out[i] = out_a_r[i];
    assign io_line_a_oe_n[i] = !md.wave;
    assign io_line_b_out[i] = out_b_r[i];
    assign io_line_b_oe_n[i] = !md.wave;
  end

  assign irq = irq_r;
  // line B input is never used by the block; it only feeds this unused reduction
  logic unused_b;
  assign unused_b = ^io_line_b_in;
endmodule : timer_counter_clock_core

`default_nettype wire

//--- hw/tc_pkg.sv
// shared constants, register map and field layouts of the three-channel timer block
package tc_pkg;
  // structure
  localparam int NUM_CH = 3;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int PRE_W = 10;
  // prescaler bit whose level is the master clock divided by 2, 8, 32, 128, 1024
  localparam int DIV2_BIT = 0;
  localparam int DIV8_BIT = 2;
  localparam int DIV32_BIT = 4;
  localparam int DIV128_BIT = 6;
  localparam int DIV1024_BIT = 9;
  // register map: channel i sits at i * CH_STRIDE
  localparam logic [7:0] CH_STRIDE = 8'h40;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CV = 8'h08;
  localparam logic [7:0] OFS_RB = 8'h0C;
  localparam logic [7:0] OFS_RC = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam logic [7:0] ADR_BCR = 8'hC0;
  localparam logic [7:0] ADR_BMR = 8'hC4;
  // command and status bit positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIS_BIT = 1;
  localparam int CTRL_SOFTWARE_TRIGGER_BIT_BIT = 2;
  localparam int BCR_SYNC_BIT = 0;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_CPC_BIT = 1;
  localparam int ST_LDB_BIT = 2;
  localparam int ST_CLOCK_ENABLED_STATUS_BIT = 16;
  localparam int NUM_FLAGS = 3;
  // clock select and burst codes
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV128 = 3'h3;
  localparam logic [2:0] CLK_DIV1024 = 3'h4;
  localparam logic [2:0] CLK_XC0 = 3'h5;
  localparam logic [2:0] CLK_XC1 = 3'h6;
  localparam logic [1:0] BURST_NONE = 2'h0;
  localparam logic [1:0] BURST_XC0 = 2'h1;
  localparam logic [1:0] BURST_XC1 = 2'h2;
  // block mode: source of each external clock input, two bits per input
  localparam logic [1:0] XSEL_PIN = 2'h0;
  localparam logic [1:0] XSEL_NEXT = 2'h2;
  localparam logic [1:0] XSEL_PREV = 2'h3;
  // reset values
  localparam logic [5:0] BMR_RST = 6'h00;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [2:0] IMASK_RST = 3'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel mode register layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic wave;       // 1 waveform, 0 capture
    logic cmp_trig;   // compare C match triggers the channel
    logic cmp_dis;    // compare_c_disable_bit
    logic cmp_stop;   // compare_c_stop_bit
    logic ldb_dis;    // load_b_disable_bit
    logic ldb_stop;   // load_b_stop_bit
    logic [1:0] burst;
    logic invert;     // clock_invert_bit
    logic [2:0] clk_sel;
  } mode_s;
endpackage : tc_pkg

//--- dv/tc_core_asserts.sv
// assertion checker for the timer counter core bus and line pins
`timescale 1ns/1ps
`default_nettype none
module tc_core_asserts
  import tc_pkg::*;
#(
  parameter int NUM_CH = tc_pkg::NUM_CH,
  parameter int CNT_W = tc_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CH-1:0] io_line_a_out,
  input wire logic [NUM_CH-1:0] io_line_a_oe_n,
  input wire logic [NUM_CH-1:0] io_line_b_oe_n,
  input wire logic [NUM_CH-1:0] irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer dropped");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer missing");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write answer dropped");
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block)
    else $error("write taken while answering");
  property p_slverr;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("refused read data not zero");
  property p_reset;
    $rose(aresetn) |-> &io_line_a_oe_n && irq == '0 && !s_axi_rvalid && !s_axi_bvalid;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs wrong after reset");
  property p_oe_pair;
    io_line_a_oe_n == io_line_b_oe_n;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("line drive enables differ");
  property p_oe_write;
    $changed(io_line_a_oe_n) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("line direction changed without write");
  property p_line_a_still;
    &io_line_a_oe_n && &$past(io_line_a_oe_n) |-> $stable(io_line_a_out);
  endproperty
  a_line_a_still: assert property (p_line_a_still)
    else $error("line A moved in capture mode");
endmodule : tc_core_asserts
bind timer_counter_clock_core tc_core_asserts #(.NUM_CH(NUM_CH), .CNT_W(CNT_W))
  i_tc_core_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .io_line_a_out, .io_line_a_oe_n, .io_line_b_oe_n, .irq);
`default_nettype wire

//--- dv/ext_src.sv
// model of the external clock sources and line inputs
`timescale 1ns/1ps
`default_nettype none
module ext_src #(
  parameter int HALF = 3,
  parameter int LOW = 2
) (
  input wire logic aclk,
  input wire logic run,
  output logic [2:0] pins,
  output logic [2:0] line_a,
  output logic [2:0] line_b
);
  int cnt = 0;
  logic lvl = 1'b0;
  logic [2:0] pat = 3'h5;
  // slow clock, high for HALF and low for LOW periods; a stop finishes the high level
  // an odd period makes a gated prescaler count independent of the prescaler phase
  always @(posedge aclk) begin
    if (!run && !lvl) begin
      cnt <= 0;
    end else if (cnt == (lvl ? HALF : LOW) - 1) begin
      cnt <= 0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // line B is never read by the block, so it never settles
  always @(posedge aclk) pat <= ~pat;
  assign pins = {3{lvl}};
  assign line_a = {3{lvl}};
  assign line_b = pat;
endmodule : ext_src
`default_nettype wire

//--- dv/timer_counter_clock_core_test.sv
// self-checking bench for the three-channel timer counter core
`timescale 1ns/1ps
`default_nettype none
module timer_counter_clock_core_test;
  import tc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] a_out, a_oe_n, b_out, b_oe_n, irq, pins, pa, pb, a_in, b_in;
  int n_fail = 0, n_checks = 0, cyc = 0;
  // each line carries the block's value where it drives, else the far side's
  assign a_in = (a_oe_n & pa) | (~a_oe_n & a_out);
  assign b_in = (b_oe_n & pb) | (~b_oe_n & b_out);
  timer_counter_clock_core i_timer_counter_clock_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clock_pins(pins), .io_line_a_in(a_in), .io_line_a_out(a_out),
    .io_line_a_oe_n(a_oe_n), .io_line_b_in(b_in), .io_line_b_out(b_out),
    .io_line_b_oe_n(b_oe_n), .irq(irq));
  ext_src i_ext_src (.aclk(aclk), .run(run), .pins(pins), .line_a(pa), .line_b(pb));
  always #50 aclk = ~aclk;
  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_near(input string nm, input int e, input logic [31:0] g, input int t);
    n_checks++;
    if (^g === 1'bx || g > e + t || g + t < e) begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_near
  function automatic int exp_cnt(input int s, input int n);
    int sh[5] = '{1, 3, 5, 7, 10};
    return n >> sh[s];
  endfunction : exp_cnt
  function automatic logic [7:0] ad(input int c, input logic [7:0] o);
    return 8'(c) * CH_STRIDE + o;
  endfunction : ad
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw, hb, sb;
    da = 1'b0;
    dw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom_range(1, 0)); // a late bready makes the slave hold its answer
    do begin
      @(negedge aclk);
      ta = !da && awready;
      tw = !dw && wready;
      sb = bvalid;
      hb = bvalid && bready;
      @(posedge aclk);
      if (sb && !hb) bready <= 1'b1;
      if (ta) begin
        da = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw) begin
        dw = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!hb);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, hr, hv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom_range(1, 0)); // a late rready makes the slave hold its answer
    do begin
      @(negedge aclk);
      ta = arready;
      hv = rvalid;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (hv && !hr) rready <= 1'b1;
    end while (!hr);
  endtask : rd
  // enable first: a trigger in the same write as the enable finds the clock disabled
  task automatic start(input int c);
    wr(ad(c, OFS_CTRL), 32'h1);
    wr(ad(c, OFS_CTRL), 32'h4);
  endtask : start
  initial begin
    logic [31:0] d, rc;
    logic [1:0] r;
    int t0;
    void'($urandom(32'h838d));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int c = 0; c < 3; c++) begin
      rd(ad(c, OFS_CV), d, r);
      chk("count", 32'h0, d);
      rd(ad(c, OFS_STAT), d, r);
      chk("status", 32'h0, d);
      rd(ad(c, OFS_MODE), d, r);
      chk("mode", {16'h0, MODE_RST}, d);
    end
    rd(8'h30, d, r);
    chk("refused resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    // trigger with the clock still disabled
    wr(ad(0, OFS_CTRL), 32'h4);
    repeat (50) @(posedge aclk);
    rd(ad(0, OFS_CV), d, r);
    chk("count", 32'h0, d);
    // every internal clock, inversion drawn at random
    for (int s = 0; s < 5; s++) begin
      wr(ad(0, OFS_MODE), {28'h0, 1'($urandom_range(1, 0)), 3'(s)});
      start(0);
      t0 = cyc;
      repeat (1100 + $urandom_range(900, 0)) @(posedge aclk);
      rd(ad(0, OFS_CV), d, r);
      chk_near("count", exp_cnt(s, cyc - t0), d, 3);
      rd(ad(0, OFS_STAT), d, r);
      chk("enabled", 32'h1, 32'(d[ST_CLOCK_ENABLED_STATUS_BIT]));
    end
    wr(ad(0, OFS_CTRL), 32'h3);
    rd(ad(0, OFS_STAT), d, r);
    chk("enabled", 32'h0, 32'(d[ST_CLOCK_ENABLED_STATUS_BIT]));
    // block start with channel 2 left disabled
    for (int c = 0; c < 2; c++) begin
      wr(ad(c, OFS_MODE), {29'h0, CLK_DIV8});
      wr(ad(c, OFS_CTRL), 32'h1);
    end
    wr(ADR_BCR, 32'h1);
    t0 = cyc;
    repeat (400) @(posedge aclk);
    for (int c = 0; c < 3; c++) begin
      rd(ad(c, OFS_CV), d, r);
      chk_near("count", c < 2 ? exp_cnt(1, cyc - t0) : 0, d, 3);
    end
    // compare C stop, then compare C disable, with the interrupt unmasked
    for (int k = 0; k < 2; k++) begin
      rc = 32'(10 + $urandom_range(30, 0));
      wr(ad(1, OFS_RC), rc);
      wr(ad(1, OFS_IMASK), 32'h2);
      wr(ad(1, OFS_MODE), k ? 32'h0A00 : 32'h0900);
      start(1);
      repeat (200) @(posedge aclk);
      @(negedge aclk);
      chk("irq", 32'h1, 32'(irq[1]));
      chk("line a drive", 32'h0, 32'(a_oe_n[1]));
      @(posedge aclk);
      rd(ad(1, OFS_CV), d, r);
      chk("count", rc, d);
      rd(ad(1, OFS_STAT), d, r);
      chk("status", k ? 32'h2 : 32'h10002, d);
      repeat (3) @(negedge aclk);
      chk("irq", 32'h0, 32'(irq[1]));
      @(posedge aclk);
    end
    // gate from pin 1, chain channel 0 to line A of channel 2
    wr(ADR_BMR, 32'h3);
    wr(ad(2, OFS_MODE), 32'h20);
    start(2);
    repeat (100) @(posedge aclk);
    rd(ad(2, OFS_CV), d, r);
    chk("count", 32'h0, d);
    wr(ad(0, OFS_MODE), {29'h0, CLK_XC0});
    start(0);
    run <= 1'b1;
    t0 = cyc;
    repeat (600) @(posedge aclk);
    rd(ad(0, OFS_CV), d, r);
    // far clock period is 5 cycles, first edge about 8 cycles late, first edge only zeroes
    chk_near("chained count", (cyc - t0 - 8) / 5, d, 3);
    rd(ad(2, OFS_CV), d, r);
    // gate high 3 of every 5 cycles lets 3 half-rate edges through per 10 cycles
    chk_near("gated count", (cyc - t0 - 8) * 3 / 10 - 1, d, 4);
    // capture load on line A with the load-B disable bit set drops the clock enable
    wr(ad(2, OFS_MODE), 32'h80);
    repeat (20) @(posedge aclk);
    rd(ad(2, OFS_STAT), d, r);
    chk("enabled", 32'h0, 32'(d[ST_CLOCK_ENABLED_STATUS_BIT]));
    give_verdict;
  end
endmodule : timer_counter_clock_core_test
`default_nettype wire
